// ### core/cpf_chk_if.sv
// Purpose: Carries a register privilege query from the filter to its checker.
// Assumes: Purely combinational answer.
// Notes:   Allow-list windows are owned by the filter's register file.
`timescale 1ns/10ps
interface cpf_chk_if;
  logic [3:0]  sid;
  logic [20:0] ofs;
  logic [31:0] allow [cpf_pkg::CPF_N_ALLOW];
  logic        reg_priv;
  modport requester (output sid, output ofs, output allow, input reg_priv);
  modport decider (input sid, input ofs, input allow, output reg_priv);
endinterface : cpf_chk_if

// ### core/cpf_filter.sv
// Purpose: Privilege filter stage of a command streamer parser, with APB registers.
// Assumes: Commands arrive predecoded; one clock, synchronous active-low reset.
// Notes:   One command every two cycles at most; outputs are registered.
//
// Summary of operation
// - Buffers in global translation space are privileged, per-process ones not.
// - Privileged commands run normally only from privileged buffers or the ring.
// - Privileged command in non-privileged buffer raises violation and is discarded.
// - Violation is recorded in error identity register and raises the interrupt when mask bit 0 is set.
// - Privilege check disable bit skips all checks.
// - Table update, indexed store, context set, arbitration, flip always become no-ops.
// - Global-flagged store, atomic, wait, load, conditional end, perf report become no-ops.
// - Register loads to privileged registers are no-ops; copies lose their write.
// - Register-to-memory store always reads, drops memory write if global.
// - Memory copy proceeds only if neither address is global.
// - Flushes still go down; post-sync dropped if global or indexed flag.
// - Post-sync register load to privileged register is dropped.
// - Child buffer privilege is never above its parent's.
// - Non-privileged register writes only hit allow-list windows.
// - Register privilege is relative to render, position and blitter bases.
// - Video and enhancement streamers use their own bases.
`timescale 1ns/10ps
module cpf_filter (
  // Clock and reset.
  input  wire logic        CLK_I,
  input  wire logic        RESETN_I,
  // APB slave.
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic             PREADY_O,
  output logic [31:0]      PRDATA_O,
  output logic             PSLVERR_O,
  // Command input.
  input  wire logic        CMD_VALID_I,
  output logic             CMD_READY_O,
  input  wire logic [5:0]  CMD_CODE_I,
  input  wire logic        CMD_GLOBAL_I,
  input  wire logic        CMD_SRC_GLOBAL_I,
  input  wire logic        CMD_DST_GLOBAL_I,
  input  wire logic        CMD_INDEX_I,
  input  wire logic        CMD_PS_LOAD_I,
  input  wire logic        CMD_SECOND_I,
  input  wire logic [20:0] CMD_REG_OFS_I,
  // Filtered command output.
  output logic             OUT_VALID_O,
  input  wire logic        OUT_READY_I,
  output logic [5:0]       OUT_CODE_O,
  output logic             OUT_PRIV_O,
  output logic             OUT_NOOP_O,
  output logic             OUT_MEM_WR_DROP_O,
  output logic             OUT_REG_WR_DROP_O,
  output logic             OUT_PS_DROP_O,
  // Interrupt.
  output logic             IRQ_O
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  cpf_chk_if chk_if ();
  cpf_pkg::cpf_level_e level_reg, level_next;
  logic        first_priv_reg, first_priv_next;
  logic        second_priv_reg, second_priv_next;
  logic [31:0] mode_reg, mode_next;
  logic [31:0] status_reg, status_next;
  logic [31:0] mask_reg, mask_next;
  logic [31:0] err_id_reg, err_id_next;
  logic [31:0] allow_reg [cpf_pkg::CPF_N_ALLOW];
  logic        pready_reg;
  logic [31:0] prdata_reg;
  logic        pslverr_reg;
  logic        out_valid_reg, out_valid_next;
  logic        cmd_ready_reg;
  logic [5:0]  out_code_reg;
  logic        out_priv_reg, out_noop_reg, out_mem_drop_reg, out_reg_drop_reg, out_ps_drop_reg;
  logic        irq_reg;
  logic        accept, launch, buf_end, cur_priv, in_batch, pcd, np;
  logic        is_uncond, is_glob, is_load, copy_bad, lri_bad;
  logic        noop, mem_drop, reg_drop, ps_drop, viol;
  logic        apb_access, apb_wr, apb_rd_phase, addr_hit;
  logic [31:0] rd_mux;
  logic [2:0]  allow_idx;

  // ----------------------------------------------------------------
  // Register privilege checker
  // ----------------------------------------------------------------
  // streamer base selection
  assign chk_if.sid   = mode_reg[cpf_pkg::CPF_POS_SID +: 4];
  assign chk_if.ofs   = CMD_REG_OFS_I;
  assign chk_if.allow = allow_reg;

  cpf_reg_chk u_chk (
    .chk (chk_if.decider)
  );

  // ----------------------------------------------------------------
  // Buffer privilege and nesting
  // ----------------------------------------------------------------
  // Handshake terms and command classes.
  assign accept   = CMD_VALID_I && cmd_ready_reg;
  assign launch   = accept && (CMD_CODE_I == cpf_pkg::CPF_CMD_BUF_LAUNCH);
  assign buf_end  = accept && (CMD_CODE_I == cpf_pkg::CPF_CMD_BUF_END);
  assign in_batch = level_reg != cpf_pkg::CPF_LVL_RING;
  assign cur_priv = (level_reg == cpf_pkg::CPF_LVL_RING) ? 1'b1 :
                    (level_reg == cpf_pkg::CPF_LVL_FIRST) ? first_priv_reg : second_priv_reg;
  assign pcd      = mode_reg[cpf_pkg::CPF_BIT_PCD];
  assign np       = in_batch && !cur_priv && !pcd;

  // Nesting state machine; a launch from second level chains in place.
  always_comb begin
    level_next       = level_reg;
    first_priv_next  = first_priv_reg;
    second_priv_next = second_priv_reg;
    case (level_reg)
      cpf_pkg::CPF_LVL_RING: begin
        if (launch) begin
          level_next      = cpf_pkg::CPF_LVL_FIRST;
          first_priv_next = CMD_GLOBAL_I;
        end
      end
      cpf_pkg::CPF_LVL_FIRST: begin
        if (launch && CMD_SECOND_I) begin
          level_next       = cpf_pkg::CPF_LVL_SECOND;
          second_priv_next = first_priv_reg && CMD_GLOBAL_I;
        end else if (launch) begin
          first_priv_next = first_priv_reg && CMD_GLOBAL_I;
        end else if (buf_end) begin
          level_next = cpf_pkg::CPF_LVL_RING;
        end
      end
      cpf_pkg::CPF_LVL_SECOND: begin
        if (launch) begin
          second_priv_next = second_priv_reg && CMD_GLOBAL_I;
        end else if (buf_end) begin
          level_next = cpf_pkg::CPF_LVL_FIRST;
        end
      end
      default: begin
        level_next = cpf_pkg::CPF_LVL_RING;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Command restriction decisions
  // ----------------------------------------------------------------
  // unconditional no-op list
  assign is_uncond = (CMD_CODE_I == cpf_pkg::CPF_CMD_XLATE_UPDATE) || (CMD_CODE_I == cpf_pkg::CPF_CMD_IDX_STORE) ||
                     (CMD_CODE_I == cpf_pkg::CPF_CMD_CTX_SET) || (CMD_CODE_I == cpf_pkg::CPF_CMD_ARB_TOGGLE) ||
                     (CMD_CODE_I == cpf_pkg::CPF_CMD_DISP_FLIP);
  assign is_glob   = CMD_GLOBAL_I && ((CMD_CODE_I == cpf_pkg::CPF_CMD_IMM_STORE) ||
                     (CMD_CODE_I == cpf_pkg::CPF_CMD_ATOMIC) || (CMD_CODE_I == cpf_pkg::CPF_CMD_SEMA_WAIT) ||
                     (CMD_CODE_I == cpf_pkg::CPF_CMD_LOAD_MEM) || (CMD_CODE_I == cpf_pkg::CPF_CMD_COND_END) ||
                     (CMD_CODE_I == cpf_pkg::CPF_CMD_PERF_REPORT));
  assign is_load   = (CMD_CODE_I == cpf_pkg::CPF_CMD_LOAD_IMM) || (CMD_CODE_I == cpf_pkg::CPF_CMD_LOAD_MEM);
  assign lri_bad   = is_load && chk_if.reg_priv;
  assign copy_bad  = (CMD_CODE_I == cpf_pkg::CPF_CMD_MEM_COPY) && (CMD_SRC_GLOBAL_I || CMD_DST_GLOBAL_I);
  assign noop      = np && (is_uncond || is_glob || lri_bad || copy_bad);
  assign reg_drop  = np && (CMD_CODE_I == cpf_pkg::CPF_CMD_REG_COPY) && chk_if.reg_priv;
  assign mem_drop  = np && (CMD_CODE_I == cpf_pkg::CPF_CMD_REG_STORE) && CMD_GLOBAL_I;
  assign ps_drop   = np && ((CMD_CODE_I == cpf_pkg::CPF_CMD_PIPE_CTRL) || (CMD_CODE_I == cpf_pkg::CPF_CMD_FLUSH)) &&
                     (CMD_GLOBAL_I || CMD_INDEX_I || (CMD_PS_LOAD_I && chk_if.reg_priv));
  assign viol      = accept && (noop || reg_drop || mem_drop || ps_drop);

  // ----------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------
  // Slot is refilled only when empty, so ready can come from a flop.
  assign out_valid_next = accept ? 1'b1 : (out_valid_reg && !OUT_READY_I);

  // Output slot and handshake.
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      out_valid_reg <= 1'b0;
      cmd_ready_reg <= 1'b0;
    end else begin
      out_valid_reg <= out_valid_next;
      cmd_ready_reg <= !out_valid_next;
    end
  end

  // Command payload and decisions.
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      out_code_reg     <= cpf_pkg::CPF_CMD_NOOP;
      out_priv_reg     <= 1'b1;
      out_noop_reg     <= 1'b0;
      out_mem_drop_reg <= 1'b0;
      out_reg_drop_reg <= 1'b0;
      out_ps_drop_reg  <= 1'b0;
    end else if (accept) begin
      out_code_reg     <= CMD_CODE_I;
      out_priv_reg     <= cur_priv;
      out_noop_reg     <= noop;
      out_mem_drop_reg <= mem_drop;
      out_reg_drop_reg <= reg_drop;
      out_ps_drop_reg  <= ps_drop;
    end
  end

  // Nesting registers.
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      level_reg       <= cpf_pkg::CPF_LVL_RING;
      first_priv_reg  <= 1'b1;
      second_priv_reg <= 1'b1;
    end else begin
      level_reg       <= level_next;
      first_priv_reg  <= first_priv_next;
      second_priv_reg <= second_priv_next;
    end
  end

  // ----------------------------------------------------------------
  // APB register file
  // ----------------------------------------------------------------
  // Access is answered one cycle into the access phase.
  assign apb_access   = PSEL_I && PENABLE_I;
  assign apb_rd_phase = apb_access && !pready_reg;
  assign apb_wr       = apb_access && pready_reg && PWRITE_I && !pslverr_reg;
  assign allow_idx    = 3'(PADDR_I[4:2]);
  assign addr_hit     = (PADDR_I == cpf_pkg::CPF_OFS_MODE) || (PADDR_I == cpf_pkg::CPF_OFS_STATUS) ||
                        (PADDR_I == cpf_pkg::CPF_OFS_MASK) || (PADDR_I == cpf_pkg::CPF_OFS_ERR_ID) ||
                        (PADDR_I == cpf_pkg::CPF_OFS_LEVEL) ||
                        ((PADDR_I[7:4] == cpf_pkg::CPF_OFS_ALLOW0[7:4]) && (PADDR_I[1:0] == 2'h0) &&
                         (allow_idx < 3'(cpf_pkg::CPF_N_ALLOW)));

  // Read selection.
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (PADDR_I == cpf_pkg::CPF_OFS_MODE) begin
      rd_mux = mode_reg;
    end else if (PADDR_I == cpf_pkg::CPF_OFS_STATUS) begin
      rd_mux = status_reg;
    end else if (PADDR_I == cpf_pkg::CPF_OFS_MASK) begin
      rd_mux = mask_reg;
    end else if (PADDR_I == cpf_pkg::CPF_OFS_ERR_ID) begin
      rd_mux = err_id_reg;
    end else if (PADDR_I == cpf_pkg::CPF_OFS_LEVEL) begin
      rd_mux = {29'h0000_0000, cur_priv, level_reg};
    end else if (addr_hit) begin
      rd_mux = allow_reg[allow_idx[1:0]];
    end
  end

  // Next values; a violation in the clearing cycle keeps its bit set.
  assign mode_next   = (apb_wr && PADDR_I == cpf_pkg::CPF_OFS_MODE) ? {24'h000000, PWDATA_I[7:0]} : mode_reg;
  assign mask_next   = (apb_wr && PADDR_I == cpf_pkg::CPF_OFS_MASK) ? {31'h0, PWDATA_I[0]} : mask_reg;
  assign status_next = ((apb_wr && PADDR_I == cpf_pkg::CPF_OFS_STATUS) ? (status_reg & ~PWDATA_I) : status_reg) |
                       {31'h0, viol};
  assign err_id_next = viol ? {1'b1, 25'h0, CMD_CODE_I} : err_id_reg;

  // Control, status and interrupt registers.
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      mode_reg   <= cpf_pkg::CPF_RST_MODE;
      mask_reg   <= cpf_pkg::CPF_RST_MASK;
      status_reg <= 32'h0000_0000;
      err_id_reg <= 32'h0000_0000;
      irq_reg    <= 1'b0;
    end else begin
      mode_reg   <= mode_next;
      mask_reg   <= mask_next;
      status_reg <= status_next;
      err_id_reg <= err_id_next;
      irq_reg    <= |(status_next & mask_next);
    end
  end

  // Allow-list windows, one per generate entry.
  genvar a;
  generate
    for (a = 0; a < cpf_pkg::CPF_N_ALLOW; a++) begin : g_allow
      always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
          allow_reg[a] <= cpf_pkg::CPF_RST_ALLOW;
        end else if (apb_wr && addr_hit && PADDR_I[7:4] == cpf_pkg::CPF_OFS_ALLOW0[7:4] && allow_idx == 3'(a)) begin
          allow_reg[a] <= {8'h00, PWDATA_I[23:0]};
        end
      end
    end
  endgenerate

  // APB answer registers.
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= apb_rd_phase;
      prdata_reg  <= apb_rd_phase ? rd_mux : 32'h0000_0000;
      pslverr_reg <= apb_rd_phase && !addr_hit;
    end
  end

  // Port drivers.
  assign PREADY_O          = pready_reg;
  assign PRDATA_O          = prdata_reg;
  assign PSLVERR_O         = pslverr_reg;
  assign CMD_READY_O       = cmd_ready_reg;
  assign OUT_VALID_O       = out_valid_reg;
  assign OUT_CODE_O        = out_code_reg;
  assign OUT_PRIV_O        = out_priv_reg;
  assign OUT_NOOP_O        = out_noop_reg;
  assign OUT_MEM_WR_DROP_O = out_mem_drop_reg;
  assign OUT_REG_WR_DROP_O = out_reg_drop_reg;
  assign OUT_PS_DROP_O     = out_ps_drop_reg;
  assign IRQ_O             = irq_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);

  sequence take_s (logic [5:0] c);
    accept && CMD_CODE_I == c;
  endsequence

  ring_priv_a: assert property (accept && level_reg == cpf_pkg::CPF_LVL_RING |=> OUT_PRIV_O && !OUT_NOOP_O)
    else $error("Ring command was restricted.");
  uncond_noop_a: assert property (accept && np && is_uncond |=> OUT_VALID_O && OUT_NOOP_O)
    else $error("Listed command not turned into no-op.");
  global_noop_a: assert property (take_s(cpf_pkg::CPF_CMD_ATOMIC) ##0 np && CMD_GLOBAL_I |=> OUT_NOOP_O)
    else $error("Global atomic not turned into no-op.");
  check_disable_a: assert property (accept && pcd |=> !OUT_NOOP_O && !OUT_PS_DROP_O && !OUT_MEM_WR_DROP_O)
    else $error("Restriction applied while checks disabled.");
  viol_irq_a: assert property (viol && mask_next[0] |=> status_reg[0] && err_id_reg[31] && IRQ_O)
    else $error("Violation not recorded or interrupt missing.");
  viol_drop_a: assert property (viol |=> OUT_NOOP_O || OUT_REG_WR_DROP_O || OUT_MEM_WR_DROP_O || OUT_PS_DROP_O)
    else $error("Violation without discard.");
  child_priv_a: assert property (launch && in_batch && !cur_priv |=> !cur_priv)
    else $error("Child buffer gained privilege.");
  reg_store_a: assert property (take_s(cpf_pkg::CPF_CMD_REG_STORE) ##0 np |=>
    !OUT_NOOP_O && OUT_MEM_WR_DROP_O == $past(CMD_GLOBAL_I))
    else $error("Register store handled wrongly.");
  mem_copy_a: assert property (take_s(cpf_pkg::CPF_CMD_MEM_COPY) ##0 np |=>
    OUT_NOOP_O == ($past(CMD_SRC_GLOBAL_I) || $past(CMD_DST_GLOBAL_I)))
    else $error("Memory copy handled wrongly.");
  pass_through_a: assert property (take_s(cpf_pkg::CPF_CMD_NOOP) |=> !OUT_NOOP_O && OUT_CODE_O == cpf_pkg::CPF_CMD_NOOP)
    else $error("Unlisted command altered.");

endmodule : cpf_filter

// ### core/cpf_pkg.sv
// Purpose: Shared constants for the command privilege filter.
// Assumes: One parser clock; register offsets are byte addresses on APB.
// Notes:   Command codes are the filter's own compact encoding of the parser opcodes.
package cpf_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int CPF_W_CODE  = 6;
  localparam int CPF_W_OFS   = 21;
  localparam int CPF_W_SID   = 4;
  localparam int CPF_N_ALLOW = 4;
  localparam int CPF_N_STRM  = 15;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [5:0] CPF_CMD_NOOP         = 6'h00;
  localparam logic [5:0] CPF_CMD_XLATE_UPDATE = 6'h01;
  localparam logic [5:0] CPF_CMD_IMM_STORE    = 6'h02;
  localparam logic [5:0] CPF_CMD_IDX_STORE    = 6'h03;
  localparam logic [5:0] CPF_CMD_REG_STORE    = 6'h04;
  localparam logic [5:0] CPF_CMD_BUF_LAUNCH   = 6'h05;
  localparam logic [5:0] CPF_CMD_LOAD_IMM     = 6'h06;
  localparam logic [5:0] CPF_CMD_LOAD_MEM     = 6'h07;
  localparam logic [5:0] CPF_CMD_REG_COPY     = 6'h08;
  localparam logic [5:0] CPF_CMD_PERF_REPORT  = 6'h09;
  localparam logic [5:0] CPF_CMD_PIPE_CTRL    = 6'h0a;
  localparam logic [5:0] CPF_CMD_CTX_SET      = 6'h0b;
  localparam logic [5:0] CPF_CMD_ATOMIC       = 6'h0c;
  localparam logic [5:0] CPF_CMD_MEM_COPY     = 6'h0d;
  localparam logic [5:0] CPF_CMD_SEMA_WAIT    = 6'h0e;
  localparam logic [5:0] CPF_CMD_ARB_TOGGLE   = 6'h0f;
  localparam logic [5:0] CPF_CMD_DISP_FLIP    = 6'h10;
  localparam logic [5:0] CPF_CMD_COND_END     = 6'h11;
  localparam logic [5:0] CPF_CMD_FLUSH        = 6'h12;
  localparam logic [5:0] CPF_CMD_BUF_END      = 6'h13;

  // ----------------------------------------------------------------
  // Streamer identifiers and register bases
  // ----------------------------------------------------------------
  localparam logic [3:0] CPF_SID_RENDER   = 4'h0;
  localparam logic [3:0] CPF_SID_POSITION = 4'h1;
  localparam logic [3:0] CPF_SID_BLITTER  = 4'h2;
  localparam logic [3:0] CPF_SID_VIDEO0   = 4'h3;
  localparam logic [3:0] CPF_SID_VENH0    = 4'hb;
  localparam logic [20:0] CPF_STRM_BASE [CPF_N_STRM] = '{
    21'h002000, 21'h018000, 21'h022000,
    21'h1c0000, 21'h1c4000, 21'h1d0000, 21'h1d4000,
    21'h1e0000, 21'h1e4000, 21'h1f0000, 21'h1f4000,
    21'h1c8000, 21'h1d8000, 21'h1e8000, 21'h1f8000};

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] CPF_OFS_MODE    = 8'h00;
  localparam logic [7:0] CPF_OFS_STATUS  = 8'h04;
  localparam logic [7:0] CPF_OFS_MASK    = 8'h08;
  localparam logic [7:0] CPF_OFS_ERR_ID  = 8'h0c;
  localparam logic [7:0] CPF_OFS_LEVEL   = 8'h10;
  localparam logic [7:0] CPF_OFS_ALLOW0  = 8'h20;
  localparam int         CPF_BIT_PCD     = 0;
  localparam int         CPF_POS_SID     = 4;
  localparam int         CPF_BIT_VIOL    = 0;
  localparam int         CPF_BIT_ERR_VLD = 31;
  localparam int         CPF_POS_ALEN    = 16;
  localparam logic [31:0] CPF_RST_MODE   = 32'h0000_0000;
  localparam logic [31:0] CPF_RST_MASK   = 32'h0000_0000;
  localparam logic [31:0] CPF_RST_ALLOW  = 32'h0000_0000;

  // Nesting level of the buffer being parsed.
  typedef enum logic [1:0] {CPF_LVL_RING, CPF_LVL_FIRST, CPF_LVL_SECOND} cpf_level_e;

endpackage : cpf_pkg

// ### core/cpf_reg_chk.sv
// Purpose: Decides whether a register offset is privileged for one streamer.
// Assumes: Offsets are absolute; windows are relative to the streamer base.
// Notes:   Window length counts 32-bit registers; zero length disables it.
`timescale 1ns/10ps
module cpf_reg_chk (
  // Query and answer.
  cpf_chk_if.decider chk
);

  logic [20:0] base;
  logic [20:0] rel;
  logic        below;
  logic [cpf_pkg::CPF_N_ALLOW-1:0] hit;

  // Base chosen by streamer; unknown streamers get the render base.
  assign base  = (chk.sid < 4'(cpf_pkg::CPF_N_STRM)) ? cpf_pkg::CPF_STRM_BASE[chk.sid]
                                                     : cpf_pkg::CPF_STRM_BASE[0];
  assign rel   = chk.ofs - base;
  assign below = chk.ofs < base;

  // One comparator per allow-list window.
  genvar g;
  generate
    for (g = 0; g < cpf_pkg::CPF_N_ALLOW; g++) begin : g_win
      logic [20:0] w_lo;
      logic [20:0] w_hi;
      assign w_lo   = {5'h00, chk.allow[g][15:0]};
      assign w_hi   = w_lo + {11'h000, chk.allow[g][23:16], 2'h0};
      assign hit[g] = !below && (rel >= w_lo) && (rel < w_hi);
    end
  endgenerate

  assign chk.reg_priv = ~|hit;

endmodule : cpf_reg_chk

// ### verif/cpf_cmd_src.sv
// Purpose: Driver-side source of command buffer entries.
// Assumes: Requests change just after a rising edge.
// Notes:   Released fields show the inverse of the last command.
`timescale 1ns/10ps
module cpf_cmd_src (
  // Handshake.
  input  wire logic        clk_i,
  input  wire logic        ready_i,
  output logic             valid_o = 1'b0,
  // Command fields.
  output logic [5:0]       code_o = 6'h00,
  output logic [5:0]       flag_o = 6'h00,
  output logic [20:0]      ofs_o = 21'h000000
);
  // Offers one command and holds it until the filter takes it.
  task send(input logic [5:0] c, input logic [5:0] f, input logic [20:0] o);
    @(posedge clk_i);
    valid_o <= 1'b1;
    code_o  <= c;
    flag_o  <= f;
    ofs_o   <= o;
    @(posedge clk_i);
    while (ready_i !== 1'b1) @(posedge clk_i);
    valid_o <= 1'b0;
    code_o  <= ~c;
    flag_o  <= ~f;
    ofs_o   <= ~o;
  endtask : send
endmodule : cpf_cmd_src

// ### verif/tb_command_privilege_filter.sv
// Purpose: Self-checking bench for the command privilege filter.
// Assumes: Downstream is ready except in the hold test at the end.
// Notes:   Table rows run in a non-privileged first-level buffer.
`timescale 1ns/10ps
module tb_command_privilege_filter;
  logic        clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, cvalid, cready, ovalid, opriv, onoop, omem, oreg, ops, irq;
  logic [5:0]  ccode, cflag, ocode;
  logic [20:0] cofs, base = 21'h002000;
  logic        ordy = 1'b1;
  int          n_errors = 0, compares = 0, cyc = 0;
  // Code, flags {glb,src,dst,idx,ps,second}, allowed offset, expected {priv,noop,mem,reg,ps}.
  logic [17:0] rows [23] = '{18'h01008, 18'h02808, 18'h02000, 18'h03008, 18'h04804, 18'h06008,
    18'h06020, 18'h07828, 18'h08002, 18'h09808, 18'h0a101, 18'h0a081, 18'h0b008, 18'h0c808,
    18'h0d408, 18'h0d208, 18'h0d000, 18'h0e808, 18'h0f008, 18'h10008, 18'h11808, 18'h12801, 18'h00800};
  always #5 clk = ~clk;
  cpf_cmd_src src (.clk_i(clk), .ready_i(cready), .valid_o(cvalid), .code_o(ccode), .flag_o(cflag), .ofs_o(cofs));
  cpf_filter dut (.CLK_I(clk), .RESETN_I(resetn), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PREADY_O(pready), .PRDATA_O(prdata), .PSLVERR_O(pslverr),
    .CMD_VALID_I(cvalid), .CMD_READY_O(cready), .CMD_CODE_I(ccode), .CMD_GLOBAL_I(cflag[5]),
    .CMD_SRC_GLOBAL_I(cflag[4]), .CMD_DST_GLOBAL_I(cflag[3]), .CMD_INDEX_I(cflag[2]), .CMD_PS_LOAD_I(cflag[1]),
    .CMD_SECOND_I(cflag[0]), .CMD_REG_OFS_I(cofs), .OUT_VALID_O(ovalid), .OUT_READY_I(ordy), .OUT_CODE_O(ocode),
    .OUT_PRIV_O(opriv), .OUT_NOOP_O(onoop), .OUT_MEM_WR_DROP_O(omem), .OUT_REG_WR_DROP_O(oreg),
    .OUT_PS_DROP_O(ops), .IRQ_O(irq));
  // Compares one value and reports a mismatch at once.
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One APB transfer; the request stands until ready is sampled high.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Reads a register and compares it.
  task rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("register", e, rd);
  endtask : rdc
  // Sends one command and checks the decisions that come out for it.
  task cmd(input logic [5:0] c, input logic [5:0] f, input logic alw, input logic [4:0] e,
           input logic [4:0] m = 5'h1f);
    int k;
    k = 0;
    src.send(c, f, base + (alw ? 21'h000094 : 21'h000100));
    @(negedge clk);
    while (ovalid !== 1'b1 && k < 20) begin
      @(negedge clk);
      k++;
    end
    chk("command", {c, e & m}, {ocode, {opriv, onoop, omem, oreg, ops} & m});
  endtask : cmd
  // Prints the counts and the verdict, then ends the run.
  task results;
    $display("Comparisons %0d, errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results
  // Cuts a hang short.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      results();
    end
  end
  // Main sequence.
  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    rdc(8'h10, 32'h4);
    rdc(8'h08, 32'h0);
    rdc(8'h40, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    cmd(cpf_pkg::CPF_CMD_XLATE_UPDATE, 6'h00, 1'b0, 5'h10, 5'h1f);
    apb(1'b1, 8'h08, 32'h1);
    apb(1'b1, 8'h20, 32'h0001_0094);
    cmd(cpf_pkg::CPF_CMD_BUF_LAUNCH, 6'h00, 1'b0, 5'h00, 5'h00);
    rdc(8'h10, 32'h1);
    foreach (rows[i]) begin
      cmd(rows[i][17:12], rows[i][11:6], rows[i][5], rows[i][4:0]);
    end
    chk("irq", 32'h1, {31'h0, irq});
    rdc(8'h0c, 32'h8000_0012);
    apb(1'b1, 8'h04, 32'h1);
    rdc(8'h04, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    apb(1'b1, 8'h08, 32'h0);
    cmd(cpf_pkg::CPF_CMD_XLATE_UPDATE, 6'h00, 1'b0, 5'h08, 5'h1f);
    rdc(8'h04, 32'h1);
    chk("irq", 32'h0, {31'h0, irq});
    apb(1'b1, 8'h00, 32'h1);
    cmd(cpf_pkg::CPF_CMD_XLATE_UPDATE, 6'h00, 1'b0, 5'h00, 5'h1f);
    apb(1'b1, 8'h00, 32'h30);
    rdc(8'h00, 32'h30);
    base = 21'h1c0000;
    cmd(cpf_pkg::CPF_CMD_LOAD_IMM, 6'h00, 1'b1, 5'h00);
    cmd(cpf_pkg::CPF_CMD_LOAD_IMM, 6'h00, 1'b0, 5'h08);
    cmd(cpf_pkg::CPF_CMD_BUF_LAUNCH, 6'h21, 1'b0, 5'h00, 5'h00);
    rdc(8'h10, 32'h2);
    cmd(cpf_pkg::CPF_CMD_BUF_END, 6'h00, 1'b0, 5'h00, 5'h00);
    rdc(8'h10, 32'h1);
    cmd(cpf_pkg::CPF_CMD_BUF_END, 6'h00, 1'b0, 5'h00, 5'h00);
    rdc(8'h10, 32'h4);
    // Downstream stalls: the result must stand and no new command be taken.
    ordy <= 1'b0;
    cmd(cpf_pkg::CPF_CMD_FLUSH, 6'h00, 1'b0, 5'h10);
    repeat (3) @(negedge clk);
    chk("held", 32'h5, {29'h0, ovalid, cready, ocode == cpf_pkg::CPF_CMD_FLUSH});
    @(posedge clk);
    ordy <= 1'b1;
    repeat (2) @(negedge clk);
    chk("drained", 32'h1, {30'h0, ovalid, cready});
    results();
  end
endmodule : tb_command_privilege_filter
